// ===== src/light_prox_interrupt_thresholds.sv
// register file, thresholds, persistence and interrupt pin of the light/proximity sensor
// Function
// - near flag bit 7, set on event, write-0 clears
// - near persistence bits 6:5 select 1/4/8/16
// - light flag bit 3, set on event, write-0 clears
// - light persistence bits 2:1 select 1/4/8/16
// - combine bit 0 low: pin low on either flag
// - combine bit high: pin low on both flags
// - near low threshold at 0x03, reset 0x00
// - near high threshold at 0x04, reset 0xff
// - light low threshold split 0x05 and 0x06
// - light high threshold split 0x06 and 0x07
// - near result read-only at 0x08, reset zero
// - light result read-only 0x09/0x0a, upper nibble zero
// - test registers zero for normal operation
// - light trips when outside threshold window
// - near counts when above high threshold
// - near flag auto-clears below low threshold
`timescale 1ns/1ps
`default_nettype none
module light_prox_interrupt_thresholds
    import lp_int_pkg::*;
#(
    parameter int NEAR_WIDTH = 8,
    parameter int LIGHT_WIDTH = 12
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,

    // register port from the serial slave
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    output logic [7:0] reg_rdata_o,

    // conversion results from the converters
    input wire logic near_done_i,
    input wire logic [NEAR_WIDTH-1:0] near_data_i,
    input wire logic light_done_i,
    input wire logic [LIGHT_WIDTH-1:0] light_data_i,

    // interrupt pin, open drain, low when asserted
    output logic int_n_o,
    output logic int_oe_o,

    // high while both test registers hold zero
    output logic normal_mode_o
);
    // all block state
    typedef struct packed {
        // control register fields
        logic near_flag;
        logic [1:0] near_persistence;
        logic light_flag;
        logic [1:0] light_persistence;
        logic combine_and;

        // thresholds
        logic [NEAR_WIDTH-1:0] near_low;
        logic [NEAR_WIDTH-1:0] near_high;
        logic [LIGHT_WIDTH-1:0] light_low;
        logic [LIGHT_WIDTH-1:0] light_high;

        // latest conversion results
        logic [NEAR_WIDTH-1:0] near_result;
        logic [LIGHT_WIDTH-1:0] light_result;

        // test registers
        logic [7:0] factory_test_a;
        logic [7:0] factory_test_b;

        // read data and pin
        logic [7:0] rdata;
        logic int_active;
    } blk_state_t;

    // state and next state
    blk_state_t state_reg;
    blk_state_t state_next;

    // comparison outcomes on the incoming results
    logic near_above;
    logic near_below;
    logic light_outside;
    // persistence hits
    logic near_set_hit;
    logic near_clear_hit;
    logic light_set_hit;
    // write strobes
    logic wr_ctrl;
    // mode and control byte
    logic running;
    logic [7:0] ctrl_view;

    // the near channel compares against its two thresholds
    // the window output is left open
    window_compare #(
        .WIDTH(NEAR_WIDTH)
    ) u_near_cmp (
        .value_i(near_data_i),
        .low_i(state_reg.near_low),
        .high_i(state_reg.near_high),
        .above_o(near_above),
        .below_o(near_below),
        .outside_o()
    );

    // the light channel uses the full window
    // either side of the window trips
    window_compare #(
        .WIDTH(LIGHT_WIDTH)
    ) u_light_cmp (
        .value_i(light_data_i),
        .low_i(state_reg.light_low),
        .high_i(state_reg.light_high),
        .above_o(),
        .below_o(),
        .outside_o(light_outside)
    );

    // test registers other than zero suspend event handling
    assign running = (state_reg.factory_test_a == TEST_NORMAL)
        && (state_reg.factory_test_b == TEST_NORMAL);

    // near set run: results above the high threshold
    // counts only in normal operation
    persist_counter u_near_set (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .sample_i(near_done_i && running),
        .qualify_i(near_above),
        .persist_i(state_reg.near_persistence),
        .hit_o(near_set_hit)
    );

    // near clear run: results below the low threshold
    // shares the persistence code
    persist_counter u_near_clr (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .sample_i(near_done_i && running),
        .qualify_i(near_below),
        .persist_i(state_reg.near_persistence),
        .hit_o(near_clear_hit)
    );

    // light run: results outside the window
    // one counter for both sides
    persist_counter u_light_set (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .sample_i(light_done_i && running),
        .qualify_i(light_outside),
        .persist_i(state_reg.light_persistence),
        .hit_o(light_set_hit)
    );

    // control register write strobe
    assign wr_ctrl = reg_write_i && (reg_addr_i == ADDR_INTERRUPT_CONTROL);

    // current view of the control register, bit 4 reads zero
    always_comb begin
        ctrl_view = READ_ZERO;
        // proximity fields
        ctrl_view[NEAR_FLAG_BIT] = state_reg.near_flag;
        ctrl_view[NEAR_PERSIST_HI:NEAR_PERSIST_LO] = state_reg.near_persistence;
        // light fields
        ctrl_view[LIGHT_FLAG_BIT] = state_reg.light_flag;
        ctrl_view[LIGHT_PERSIST_HI:LIGHT_PERSIST_LO] = state_reg.light_persistence;
        // combine selection
        ctrl_view[COMBINE_BIT] = state_reg.combine_and;
    end

    // next-state logic: register writes, results, flags, read data, pin
    always_comb begin
        // hold by default
        state_next = state_reg;

        // control register fields; bit 4 is not stored
        if (wr_ctrl) begin
            // persistence codes
            state_next.near_persistence = reg_wdata_i[NEAR_PERSIST_HI:NEAR_PERSIST_LO];
            state_next.light_persistence = reg_wdata_i[LIGHT_PERSIST_HI:LIGHT_PERSIST_LO];
            // or/and selection
            state_next.combine_and = reg_wdata_i[COMBINE_BIT];
            // writing zero clears a flag, writing one keeps it
            if (!reg_wdata_i[NEAR_FLAG_BIT]) begin
                state_next.near_flag = 1'b0;
            end
            // same for the light flag
            if (!reg_wdata_i[LIGHT_FLAG_BIT]) begin
                state_next.light_flag = 1'b0;
            end
        end

        // threshold and test registers
        // split thresholds: each byte alone
        if (reg_write_i) begin
            if (reg_addr_i == ADDR_NEAR_LOW_THRESHOLD) begin
                // proximity low
                state_next.near_low = reg_wdata_i;
            end else if (reg_addr_i == ADDR_NEAR_HIGH_THRESHOLD) begin
                // proximity high
                state_next.near_high = reg_wdata_i;
            end else if (reg_addr_i == ADDR_LIGHT_TH_LOW_BYTE) begin
                // light low [7:0]
                state_next.light_low[7:0] = reg_wdata_i;
            end else if (reg_addr_i == ADDR_LIGHT_TH_SHARED) begin
                // light low [11:8], high [3:0]
                state_next.light_low[11:8] = reg_wdata_i[3:0];
                state_next.light_high[3:0] = reg_wdata_i[7:4];
            end else if (reg_addr_i == ADDR_LIGHT_TH_HIGH_BYTE) begin
                // light high [11:4]
                state_next.light_high[11:4] = reg_wdata_i;
            end else if (reg_addr_i == ADDR_FACTORY_TEST_A) begin
                // test register a
                state_next.factory_test_a = reg_wdata_i;
            end else if (reg_addr_i == ADDR_FACTORY_TEST_B) begin
                // test register b
                state_next.factory_test_b = reg_wdata_i;
            end
            // other addresses ignored
        end

        // result capture on each conversion
        // frozen while testing
        if (near_done_i && running) begin
            state_next.near_result = near_data_i;
        end
        if (light_done_i && running) begin
            // both bytes together
            state_next.light_result = light_data_i;
        end

        // hardware events after host clears so a set in the same cycle wins
        // near set beats auto clear
        if (near_set_hit) begin
            // run above high
            state_next.near_flag = 1'b1;
        end else if (near_clear_hit) begin
            // run below low
            state_next.near_flag = 1'b0;
        end
        if (light_set_hit) begin
            // run outside window
            state_next.light_flag = 1'b1;
        end

        // read mux, registered; unmapped addresses read zero
        // answers a cycle later
        if (reg_addr_i == ADDR_INTERRUPT_CONTROL) begin
            // control byte
            state_next.rdata = ctrl_view;
        end else if (reg_addr_i == ADDR_NEAR_LOW_THRESHOLD) begin
            // proximity low
            state_next.rdata = state_reg.near_low;
        end else if (reg_addr_i == ADDR_NEAR_HIGH_THRESHOLD) begin
            // proximity high
            state_next.rdata = state_reg.near_high;
        end else if (reg_addr_i == ADDR_LIGHT_TH_LOW_BYTE) begin
            // light low byte
            state_next.rdata = state_reg.light_low[7:0];
        end else if (reg_addr_i == ADDR_LIGHT_TH_SHARED) begin
            // shared nibbles
            state_next.rdata = {state_reg.light_high[3:0], state_reg.light_low[11:8]};
        end else if (reg_addr_i == ADDR_LIGHT_TH_HIGH_BYTE) begin
            // light high byte
            state_next.rdata = state_reg.light_high[11:4];
        end else if (reg_addr_i == ADDR_NEAR_RESULT) begin
            // proximity result
            state_next.rdata = state_reg.near_result;
        end else if (reg_addr_i == ADDR_LIGHT_RESULT_LOW) begin
            // light result low
            state_next.rdata = state_reg.light_result[7:0];
        end else if (reg_addr_i == ADDR_LIGHT_RESULT_HIGH) begin
            // light result high
            state_next.rdata = {4'h0, state_reg.light_result[11:8]};
        end else if (reg_addr_i == ADDR_FACTORY_TEST_A) begin
            // test register a
            state_next.rdata = state_reg.factory_test_a;
        end else if (reg_addr_i == ADDR_FACTORY_TEST_B) begin
            // test register b
            state_next.rdata = state_reg.factory_test_b;
        end else begin
            // unmapped
            state_next.rdata = READ_ZERO;
        end

        // interrupt combine from the updated flags
        if (state_next.combine_and) begin
            // both flags
            state_next.int_active = state_next.near_flag && state_next.light_flag;
        end else begin
            // either flag
            state_next.int_active = state_next.near_flag || state_next.light_flag;
        end
    end

    // state register with documented reset values
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // control fields
            state_reg.near_flag <= RST_INTERRUPT_CONTROL[NEAR_FLAG_BIT];
            state_reg.near_persistence <= RST_INTERRUPT_CONTROL[NEAR_PERSIST_HI:NEAR_PERSIST_LO];
            state_reg.light_flag <= RST_INTERRUPT_CONTROL[LIGHT_FLAG_BIT];
            state_reg.light_persistence <=
                RST_INTERRUPT_CONTROL[LIGHT_PERSIST_HI:LIGHT_PERSIST_LO];
            state_reg.combine_and <= RST_INTERRUPT_CONTROL[COMBINE_BIT];

            // thresholds
            state_reg.near_low <= RST_NEAR_LOW;
            state_reg.near_high <= RST_NEAR_HIGH;
            state_reg.light_low <= RST_LIGHT_LOW;
            state_reg.light_high <= RST_LIGHT_HIGH;

            // results
            state_reg.near_result <= RST_NEAR_RESULT;
            state_reg.light_result <= RST_LIGHT_RESULT;

            // test registers
            state_reg.factory_test_a <= RST_TEST;
            state_reg.factory_test_b <= RST_TEST;

            // read data and pin
            state_reg.rdata <= READ_ZERO;
            state_reg.int_active <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs: pin pulled low only while the interrupt is active
    // read data straight from its flip-flop
    assign reg_rdata_o = state_reg.rdata;
    // open drain: the value is always low
    assign int_n_o = 1'b0;
    assign int_oe_o = state_reg.int_active;
    assign normal_mode_o = running;
endmodule
`default_nettype wire

// ===== src/lp_int_pkg.sv
// constants, register map and field layout of the light/proximity interrupt block
package lp_int_pkg;
    // register addresses
    localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_NEAR_LOW_THRESHOLD = 8'h03;
    localparam logic [7:0] ADDR_NEAR_HIGH_THRESHOLD = 8'h04;
    localparam logic [7:0] ADDR_LIGHT_TH_LOW_BYTE = 8'h05;
    localparam logic [7:0] ADDR_LIGHT_TH_SHARED = 8'h06;
    localparam logic [7:0] ADDR_LIGHT_TH_HIGH_BYTE = 8'h07;
    localparam logic [7:0] ADDR_NEAR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_LIGHT_RESULT_LOW = 8'h09;
    localparam logic [7:0] ADDR_LIGHT_RESULT_HIGH = 8'h0a;
    localparam logic [7:0] ADDR_FACTORY_TEST_A = 8'h0e;
    localparam logic [7:0] ADDR_FACTORY_TEST_B = 8'h0f;
    // interrupt control field positions
    localparam int NEAR_FLAG_BIT = 7;
    localparam int NEAR_PERSIST_HI = 6;
    localparam int NEAR_PERSIST_LO = 5;
    localparam int UNUSED_BIT = 4;
    localparam int LIGHT_FLAG_BIT = 3;
    localparam int LIGHT_PERSIST_HI = 2;
    localparam int LIGHT_PERSIST_LO = 1;
    localparam int COMBINE_BIT = 0;
    // reset values
    localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] RST_NEAR_LOW = 8'h00;
    localparam logic [7:0] RST_NEAR_HIGH = 8'hff;
    localparam logic [11:0] RST_LIGHT_LOW = 12'h000;
    localparam logic [11:0] RST_LIGHT_HIGH = 12'hfff;
    localparam logic [7:0] RST_NEAR_RESULT = 8'h00;
    localparam logic [11:0] RST_LIGHT_RESULT = 12'h000;
    localparam logic [7:0] RST_TEST = 8'h00;
    localparam logic [7:0] TEST_NORMAL = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // persistence codes and counts
    localparam logic [1:0] PERSIST_1 = 2'h0;
    localparam logic [1:0] PERSIST_4 = 2'h1;
    localparam logic [1:0] PERSIST_8 = 2'h2;
    localparam logic [4:0] COUNT_1 = 5'h01;
    localparam logic [4:0] COUNT_4 = 5'h04;
    localparam logic [4:0] COUNT_8 = 5'h08;
    localparam logic [4:0] COUNT_16 = 5'h10;
    localparam logic [4:0] COUNT_ZERO = 5'h00;
    localparam logic [4:0] COUNT_ONE_STEP = 5'h01;
endpackage

// ===== src/persist_counter.sv
// consecutive-result counter that reports when the selected count is reached
`timescale 1ns/1ps
`default_nettype none
module persist_counter
    import lp_int_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // conversion strobe and its qualification
    input wire logic sample_i,
    input wire logic qualify_i,
    input wire logic [1:0] persist_i,
    // reached the selected run length on this sample
    output logic hit_o
);
    typedef struct packed {
        logic [4:0] count;
    } cnt_state_t;

    cnt_state_t state_reg;
    cnt_state_t state_next;
    logic [4:0] target; // run length selected by the field
    logic [4:0] bumped; // count including this sample

    // decode the persistence field
    always_comb begin
        case (persist_i)
            PERSIST_1: target = COUNT_1;
            PERSIST_4: target = COUNT_4;
            PERSIST_8: target = COUNT_8;
            default: target = COUNT_16;
        endcase
    end

    assign bumped = state_reg.count + COUNT_ONE_STEP;
    assign hit_o = sample_i && qualify_i && (bumped >= target);

    // a failing sample restarts the run; a hit restarts it too
    always_comb begin
        state_next = state_reg;
        if (sample_i) begin
            if (!qualify_i || hit_o) begin
                state_next.count = COUNT_ZERO;
            end else begin
                state_next.count = bumped;
            end
        end
    end

    // state register
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule
`default_nettype wire

// ===== src/window_compare.sv
// threshold comparison for one sensor channel
`timescale 1ns/1ps
`default_nettype none
module window_compare #(
    parameter int WIDTH = 8
) (
    // result and thresholds
    input wire logic [WIDTH-1:0] value_i,
    input wire logic [WIDTH-1:0] low_i,
    input wire logic [WIDTH-1:0] high_i,
    // comparison outcomes
    output logic above_o,
    output logic below_o,
    output logic outside_o
);
    assign above_o = value_i > high_i;
    assign below_o = value_i < low_i;
    assign outside_o = above_o || below_o;
endmodule
`default_nettype wire

// ===== tb/light_prox_interrupt_thresholds_test.sv
// self-checking bench for the light/proximity interrupt block
`timescale 1ns/1ps
`default_nettype none
module light_prox_interrupt_thresholds_test
    import lp_int_pkg::*;
;
    // addresses and reset values checked after reset
    localparam logic [7:0] RADDR [11] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h09, 8'h0a, 8'h0e, 8'h0f};
    localparam logic [7:0] RVAL [11] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'hf0, 8'hff, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr, wdata, rdata, near_data;
    logic write, near_done, light_done, int_n, int_oe, normal_mode;
    logic [11:0] light_data;
    // host and converter side
    lp_host_model host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .write_o(write), .near_done_o(near_done), .near_data_o(near_data),
        .light_done_o(light_done), .light_data_o(light_data));
    light_prox_interrupt_thresholds uut (.clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(write), .reg_rdata_o(rdata), .near_done_i(near_done),
        .near_data_i(near_data), .light_done_i(light_done), .light_data_i(light_data),
        .int_n_o(int_n), .int_oe_o(int_oe), .normal_mode_o(normal_mode));
    // 50 MHz clock
    always #10 clock_i = ~clock_i;
    // hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("MISMATCH %0t timeout", $time);
            results();
        end
    end
    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // the one compare, bits zero-extended to a byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp, $sformatf("read %h", a));
    endtask
    // reset values of all registers, the pin enable and normal mode
    task automatic t_reset();
        for (int i = 0; i < 11; i++) rdchk(RADDR[i], RVAL[i]);
        chk({7'h0, int_oe}, 8'h00, "pin after reset");
        chk({7'h0, normal_mode}, 8'h01, "normal after reset");
    endtask
    // threshold read/write and read-only results
    task automatic t_regs();
        for (int i = 1; i < 6; i++) host.wr(RADDR[i], 8'h5a ^ RADDR[i]);
        for (int i = 1; i < 6; i++) rdchk(RADDR[i], 8'h5a ^ RADDR[i]);
        host.wr(ADDR_NEAR_RESULT, 8'h77);
        host.wr(ADDR_LIGHT_RESULT_HIGH, 8'h77);
        rdchk(ADDR_NEAR_RESULT, 8'h00);
        rdchk(ADDR_LIGHT_RESULT_HIGH, 8'h00);
    endtask
    // near persistence set and auto clear, all four codes, boundary values
    task automatic t_near();
        host.wr(ADDR_NEAR_LOW_THRESHOLD, 8'h10);
        host.wr(ADDR_NEAR_HIGH_THRESHOLD, 8'h7f);
        for (int p = 0; p < 4; p++) begin
            int n;
            n = (p == 0) ? 1 : 4 << (p - 1);
            host.wr(ADDR_INTERRUPT_CONTROL, {1'b0, p[1:0], 5'h00});
            repeat (n - 1) host.near(8'h80);
            host.near(8'h7f);
            chk({7'h0, int_oe}, 8'h00, "near run broken");
            repeat (n - 1) host.near(8'h80);
            chk({7'h0, int_oe}, 8'h00, "near short run");
            host.near(8'h80);
            chk({7'h0, int_oe}, 8'h01, "near run done");
            rdchk(ADDR_INTERRUPT_CONTROL, {1'b1, p[1:0], 5'h00});
            rdchk(ADDR_NEAR_RESULT, 8'h80);
            repeat (n - 1) host.near(8'h05);
            host.near(8'h10);
            chk({7'h0, int_oe}, 8'h01, "near clear broken");
            repeat (n) host.near(8'h05);
            chk({7'h0, int_oe}, 8'h00, "near auto clear");
        end
    endtask
    // light window, persistence and host clear
    task automatic t_light();
        host.wr(ADDR_LIGHT_TH_LOW_BYTE, 8'h00);
        host.wr(ADDR_LIGHT_TH_SHARED, 8'h01);
        host.wr(ADDR_LIGHT_TH_HIGH_BYTE, 8'h80);
        for (int p = 0; p < 4; p++) begin
            int n;
            n = (p == 0) ? 1 : 4 << (p - 1);
            host.wr(ADDR_INTERRUPT_CONTROL, {5'h00, p[1:0], 1'b0});
            repeat (n - 1) host.light(12'h900);
            host.light(12'h800);
            chk({7'h0, int_oe}, 8'h00, "light run broken");
            repeat (n - 1) host.light(12'h0ff);
            chk({7'h0, int_oe}, 8'h00, "light short run");
            host.light(12'hfff);
            chk({7'h0, int_oe}, 8'h01, "light run done");
            rdchk(ADDR_INTERRUPT_CONTROL, {5'h01, p[1:0], 1'b0});
            rdchk(ADDR_LIGHT_RESULT_LOW, 8'hff);
            rdchk(ADDR_LIGHT_RESULT_HIGH, 8'h0f);
            host.wr(ADDR_INTERRUPT_CONTROL, {5'h00, p[1:0], 1'b0});
            chk({7'h0, int_oe}, 8'h00, "light host clear");
        end
    endtask
    // and/or combine and write-one keeps flags
    task automatic t_combine();
        host.wr(ADDR_INTERRUPT_CONTROL, 8'h01);
        host.near(8'h80);
        chk({7'h0, int_oe}, 8'h00, "and one flag");
        host.light(12'hfff);
        chk({7'h0, int_oe}, 8'h01, "and both flags");
        host.wr(ADDR_INTERRUPT_CONTROL, 8'h89);
        rdchk(ADDR_INTERRUPT_CONTROL, 8'h89);
        host.wr(ADDR_INTERRUPT_CONTROL, 8'h09);
        chk({7'h0, int_oe}, 8'h00, "and near cleared");
        host.wr(ADDR_INTERRUPT_CONTROL, 8'h08);
        chk({7'h0, int_oe}, 8'h01, "or light only");
        host.wr(ADDR_INTERRUPT_CONTROL, 8'h00);
        chk({7'h0, int_oe}, 8'h00, "all cleared");
    endtask
    // test register nonzero freezes conversions
    task automatic t_test();
        host.wr(ADDR_FACTORY_TEST_A, 8'h5a);
        chk({7'h0, normal_mode}, 8'h00, "test mode on");
        host.near(8'hc0);
        chk({7'h0, int_oe}, 8'h00, "frozen flag");
        rdchk(ADDR_NEAR_RESULT, 8'h80);
        rdchk(ADDR_FACTORY_TEST_A, 8'h5a);
        host.wr(ADDR_FACTORY_TEST_A, 8'h00);
        host.wr(ADDR_FACTORY_TEST_B, 8'h01);
        host.light(12'h0aa);
        chk({7'h0, int_oe}, 8'h00, "frozen light");
        rdchk(ADDR_LIGHT_RESULT_LOW, 8'hff);
        rdchk(ADDR_FACTORY_TEST_B, 8'h01);
        host.wr(ADDR_FACTORY_TEST_B, 8'h00);
        chk({7'h0, normal_mode}, 8'h01, "test mode off");
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clock_i);
        @(negedge clock_i);
        nrst_i = 1'b1;
        t_reset();
        t_regs();
        t_near();
        t_light();
        t_combine();
        t_test();
        results();
    end
endmodule
`default_nettype wire

// ===== tb/lp_host_model.sv
// host model: register writes and reads, plus the two converters' done strobes
`timescale 1ns/1ps
`default_nettype none
module lp_host_model
    import lp_int_pkg::*;
(
    // clock and read data back from the block
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    // register port and conversion strobes driven into the block
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic write_o,
    output logic near_done_o,
    output logic [7:0] near_data_o,
    output logic light_done_o,
    output logic [11:0] light_data_o
);
    // idle values at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        write_o = 1'b0;
        near_done_o = 1'b0;
        near_data_o = 8'h00;
        light_done_o = 1'b0;
        light_data_o = 12'h000;
    end
    // one-cycle write strobe, launched and dropped at falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        addr_o = a;
        wdata_o = (a == ADDR_INTERRUPT_CONTROL) ? (d & 8'hef) : d;
        write_o = 1'b1;
        @(negedge clock_i);
        write_o = 1'b0;
        wdata_o = ~wdata_o;
    endtask
    // read data shows one cycle after the address is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_i);
        addr_o = a;
        @(negedge clock_i);
        d = rdata_i;
    endtask
    // proximity result with its done pulse; data is scrambled afterwards
    task automatic near(input logic [7:0] v);
        @(negedge clock_i);
        near_done_o = 1'b1;
        near_data_o = v;
        @(negedge clock_i);
        near_done_o = 1'b0;
        near_data_o = ~v;
    endtask
    // light result with its done pulse
    task automatic light(input logic [11:0] v);
        @(negedge clock_i);
        light_done_o = 1'b1;
        light_data_o = v;
        @(negedge clock_i);
        light_done_o = 1'b0;
        light_data_o = ~v;
    endtask
endmodule
`default_nettype wire

// ===== tb/lp_int_checker.sv
// concurrent checks on the interrupt block's ports
`timescale 1ns/1ps
`default_nettype none
module lp_int_checker
    import lp_int_pkg::*;
#(
    parameter int NEAR_WIDTH = 8,
    parameter int LIGHT_WIDTH = 12
) (
    // every port of the block, as inputs
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic near_done_i,
    input wire logic [NEAR_WIDTH-1:0] near_data_i,
    input wire logic light_done_i,
    input wire logic [LIGHT_WIDTH-1:0] light_data_i,
    input wire logic int_n_o,
    input wire logic int_oe_o,
    input wire logic normal_mode_o
);
    // single clock domain
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);
    chk_pin_level: assert property (int_n_o == 1'b0)
        else $error("interrupt pin value not low");
    chk_quiet_hold: assert property (!near_done_i && !light_done_i && !reg_write_i
        |=> $stable(int_oe_o))
        else $error("interrupt moved with no cause");
    chk_test_freeze: assert property (!normal_mode_o && !reg_write_i |=> $stable(int_oe_o))
        else $error("interrupt moved in test mode");
    chk_rise_cause: assert property ($rose(int_oe_o) |-> $past(near_done_i)
        || $past(light_done_i) || $past(reg_write_i))
        else $error("interrupt rose with no cause");
    chk_fall_cause: assert property ($fell(int_oe_o)
        |-> $past(near_done_i) || $past(reg_write_i))
        else $error("interrupt fell with no cause");
    chk_nibble_zero: assert property (reg_addr_i == ADDR_LIGHT_RESULT_HIGH
        |=> reg_rdata_o[7:4] == 4'h0)
        else $error("unused result bits not zero");
    chk_spare_bit: assert property (reg_addr_i == ADDR_INTERRUPT_CONTROL
        |=> !reg_rdata_o[UNUSED_BIT])
        else $error("spare control bit reads one");
    chk_test_read: assert property (reg_addr_i == ADDR_FACTORY_TEST_A && normal_mode_o
        && !reg_write_i |=> reg_rdata_o == TEST_NORMAL)
        else $error("test register nonzero in normal mode");
endmodule
bind light_prox_interrupt_thresholds lp_int_checker #(
    .NEAR_WIDTH(NEAR_WIDTH),
    .LIGHT_WIDTH(LIGHT_WIDTH)
) chk (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i),
    .reg_rdata_o(reg_rdata_o),
    .near_done_i(near_done_i),
    .near_data_i(near_data_i),
    .light_done_i(light_done_i),
    .light_data_i(light_data_i),
    .int_n_o(int_n_o),
    .int_oe_o(int_oe_o),
    .normal_mode_o(normal_mode_o)
);
`default_nettype wire
